// ===== urfc_flow.sv
// rts/cts hardware handshake: drives cts, gates byte hand-off to the transmitter
`timescale 1ns/1ps
// Functional notes
// R1: cts output low while the receive path can accept more characters.
// R2: cts output high when the remote sender must stop.
// R3: remote sender holds off new characters while cts is high.
// R4: rts changes are watched; deassert pauses, assert resumes transmission.
// R5: rts high pauses transmitter; a byte in flight completes first.
// R6: rts low re-enables transmitter so pending bytes go out.
// R7: first port handshake works up to 230,400 bits per second.
// R8: second port handshake works up to 1 Mbit per second.
// R9: rts passes a synchroniser before its changes are detected.
module urfc_flow
  import urfc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic rts_n_i,
  output logic cts_n_o,
  input wire logic rx_space_i,
  input wire logic tx_valid_i,
  input wire logic [URFC_DATA_W-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic tx_start_o,
  output logic [URFC_DATA_W-1:0] tx_byte_o,
  input wire logic tx_busy_i,
  output logic tx_enabled_o
);

  logic [2:0] rts_sync;
  logic [2:0] next_rts_sync;
  logic rts_level;
  logic next_rts_level;
  urfc_tx_state_type state;
  urfc_tx_state_type next_state;
  logic cts_n;
  logic next_cts_n;
  logic start;
  logic next_start;
  logic [URFC_DATA_W-1:0] tx_byte;
  logic [URFC_DATA_W-1:0] next_tx_byte;
  logic in_ready;
  logic enabled;
  logic buf_valid;
  logic [URFC_DATA_W-1:0] buf_data;
  logic buf_take;

  urfc_buf u_buf (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(in_ready),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_take)
  );

  // the level changes only when stages two and three agree
  always_comb
  begin
    next_rts_sync = {rts_sync[1:0], rts_n_i}; // [R9]
    next_rts_level = rts_level;
    if (rts_sync[1] == rts_sync[2])
      next_rts_level = rts_sync[2]; // [R9] [R4]
  end

  // pause or resume as soon as the synchronised rts level changes; a byte in flight finishes
  always_comb
  begin
    next_state = state;
    unique case (state)
      URFC_TX_RUN:
        if (rts_level == URFC_DEASSERTED)
          next_state = URFC_TX_PAUSED; // [R4] [R5]
      URFC_TX_PAUSED:
        if (rts_level == URFC_ASSERTED)
          next_state = URFC_TX_RUN; // [R4] [R6]
    endcase
  end

  // hand one byte to the transmitter when it is idle and rts allows
  assign buf_take = (state == URFC_TX_RUN) && (rts_level == URFC_ASSERTED)
                    && buf_valid && !tx_busy_i && !start; // [R5] [R6]

  // rate independent: one check per clock cycle, far faster than any bit period [R7] [R8]
  always_comb
  begin
    next_start = buf_take;
    next_tx_byte = buf_take ? buf_data : tx_byte;
    next_cts_n = rx_space_i ? URFC_ASSERTED : URFC_DEASSERTED; // [R1] [R2]
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      rts_sync <= URFC_SYNC_RST;
      rts_level <= URFC_DEASSERTED;
      state <= URFC_TX_PAUSED;
      cts_n <= URFC_DEASSERTED;
      start <= 1'b0;
      tx_byte <= '0;
      enabled <= 1'b0;
    end
    else
    begin
      rts_sync <= next_rts_sync;
      rts_level <= next_rts_level;
      state <= next_state;
      cts_n <= next_cts_n;
      start <= next_start;
      tx_byte <= next_tx_byte;
      enabled <= (next_state == URFC_TX_RUN); // [R4]
    end
  end

  assign cts_n_o = cts_n;
  assign tx_start_o = start;
  assign tx_byte_o = tx_byte;
  assign tx_enabled_o = enabled;
  assign tx_ready_o = in_ready;

endmodule : urfc_flow

// ===== urfc_pkg.sv
// package for the serial handshake flow control block
package urfc_pkg;

  localparam int unsigned URFC_CLK_HZ = 100000000;
  // highest bit rates supported by the two port kinds
  localparam int unsigned URFC_PORT0_MAX_BPS = 230400;
  localparam int unsigned URFC_PORT1_MAX_BPS = 1000000;
  // fastest bit period in clock cycles (longest time rounds down)
  localparam int unsigned URFC_PORT1_MIN_BIT_CYC = URFC_CLK_HZ / URFC_PORT1_MAX_BPS;
  localparam int unsigned URFC_PORT0_MIN_BIT_CYC = URFC_CLK_HZ / URFC_PORT0_MAX_BPS;
  localparam int unsigned URFC_DATA_W = 8;
  localparam int unsigned URFC_BUF_DEPTH = 2;
  // pin levels
  localparam logic URFC_ASSERTED = 1'h0;
  localparam logic URFC_DEASSERTED = 1'h1;
  localparam logic [2:0] URFC_SYNC_RST = 3'h7;

  typedef struct packed {
    logic valid;
    logic [URFC_DATA_W-1:0] data;
  } urfc_byte_type;

  typedef enum logic [0:0] {
    URFC_TX_PAUSED,
    URFC_TX_RUN
  } urfc_tx_state_type;

endpackage : urfc_pkg

// ===== urfc_buf.sv
// two-entry skid buffer for bytes on their way to the transmitter
`timescale 1ns/1ps
module urfc_buf
  import urfc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  input wire logic [URFC_DATA_W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [URFC_DATA_W-1:0] out_data_o,
  input wire logic out_ready_i
);

  urfc_byte_type mem [URFC_BUF_DEPTH];
  urfc_byte_type next_mem [URFC_BUF_DEPTH];
  logic wr_en;
  logic rd_en;
  logic ready;
  logic next_ready;

  assign wr_en = in_valid_i && !mem[1].valid;
  assign rd_en = mem[0].valid && out_ready_i;
  // room flag kept in its own flop so the ready output is registered
  assign in_ready_o = ready;
  assign out_valid_o = mem[0].valid;
  assign out_data_o = mem[0].data;

  always_comb
  begin
    next_mem = mem;
    if (rd_en)
    begin
      next_mem[0] = mem[1];
      next_mem[1] = '0;
    end
    if (wr_en)
    begin
      if (!next_mem[0].valid)
        next_mem[0] = '{valid: 1'b1, data: in_data_i};
      else
        next_mem[1] = '{valid: 1'b1, data: in_data_i};
    end
    next_ready = !next_mem[1].valid;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      ready <= 1'b1;
    end
    else
    begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      ready <= next_ready;
    end
  end

endmodule : urfc_buf

// ===== urfc_flow_assertions.sv
// timing checks on the rts/cts handshake ports
`timescale 1ns/1ps
module urfc_flow_chk
  import urfc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic rts_n_i,
  input wire logic cts_n_o,
  input wire logic rx_space_i,
  input wire logic tx_start_o,
  input wire logic tx_busy_i,
  input wire logic tx_enabled_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence rts_off_s;
    rts_n_i[*6];
  endsequence
  sequence rts_on_s;
    !rts_n_i[*6];
  endsequence
  AST_CTS_ON: assert property (rx_space_i |=> !cts_n_o) else $error("cts stuck high");
  AST_CTS_OFF: assert property (!rx_space_i |=> cts_n_o) else $error("cts stuck low");
  AST_PAUSE: assert property (rts_off_s |-> !tx_enabled_o) else $error("no pause");
  AST_RESUME: assert property (rts_on_s |-> tx_enabled_o) else $error("no resume");
  AST_BUSY: assert property (tx_busy_i |-> !tx_start_o) else $error("start while busy");
  AST_HALT: assert property (!tx_enabled_o[*2] |-> !tx_start_o) else $error("start paused");
  AST_SYNC: assert property ($fell(rts_n_i) && !tx_enabled_o |=> !tx_enabled_o)
    else $error("rts not synchronised");
  AST_PULSE: assert property (tx_start_o |=> !tx_start_o) else $error("start too long");
endmodule : urfc_flow_chk

// ===== urfc_remote.sv
// transmitter stand-in: busy for a while after each start
`timescale 1ns/1ps
module urfc_remote
  import urfc_pkg::*;
#(
  parameter int BUSY_CYC = 6
)
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  output logic busy_o
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  // a started byte always shifts out in full
  always_comb next_cnt = start_i ? 8'(BUSY_CYC) : (cnt != 8'h00 ? cnt - 8'h01 : cnt);
  always_ff @(posedge ref_clk_i) cnt <= rstn_i ? next_cnt : 8'h00;
  assign busy_o = (cnt != 8'h00);
endmodule : urfc_remote

// ===== testbench.sv
// testbench for the rts/cts handshake block
`timescale 1ns/1ps
module testbench
  import urfc_pkg::*;
;
  logic ref_clk_i = 0, rstn_i = 0, rts_n_i = 1, rx_space_i = 0, tx_valid_i = 0;
  logic [7:0] tx_data_i = 8'h00;
  logic cts_n_o, tx_ready_o, tx_start_o, tx_busy_i, tx_enabled_o;
  logic [7:0] tx_byte_o;
  logic [7:0] got_q[$];
  int n_mismatch = 0, compares = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (tx_start_o === 1'b1) got_q.push_back(tx_byte_o);
  urfc_flow u_urfc_flow(.ref_clk_i, .rstn_i, .rts_n_i, .cts_n_o, .rx_space_i, .tx_valid_i,
    .tx_data_i, .tx_ready_o, .tx_start_o, .tx_byte_o, .tx_busy_i, .tx_enabled_o);
  urfc_remote u_urfc_remote(.ref_clk_i, .rstn_i, .start_i(tx_start_o), .busy_o(tx_busy_i));
  task automatic summarize();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic offer(input logic [7:0] b);
    int n;
    tx_valid_i = 1'b1;
    tx_data_i = b;
    n = 0;
    while (tx_ready_o !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    if (n >= 50) begin n_mismatch++; summarize(); end
    tick(1);
  endtask : offer
  task automatic wt(input int k);
    int n;
    n = 0;
    while (got_q.size() < k && n < 300) begin @(posedge ref_clk_i); n++; end
    #1;
    if (n >= 300) begin n_mismatch++; summarize(); end
  endtask : wt
  task automatic t_cts();
    int sent;
    rx_space_i = 1'b1;
    tick(2);
    chk({7'h00, cts_n_o}, 8'h00);
    rx_space_i = 1'b0;
    tick(2);
    chk({7'h00, cts_n_o}, 8'h01);
    // remote sender only sends while cts is asserted
    sent = 0;
    repeat (4)
    begin
      if (cts_n_o === URFC_ASSERTED) sent++;
      tick(1);
    end
    chk(8'(sent), 8'h00);
    $display("t_cts done");
  endtask : t_cts
  task automatic t_run();
    rts_n_i = 1'b0;
    tick(7);
    chk({7'h00, tx_enabled_o}, 8'h01);
    offer(8'hAA);
    offer(8'h55);
    offer(8'hC3);
    tx_valid_i = 1'b0;
    wt(3);
    chk(got_q[0], 8'hAA);
    chk(got_q[1], 8'h55);
    chk(got_q[2], 8'hC3);
    $display("t_run done");
  endtask : t_run
  task automatic t_pause();
    offer(8'h11);
    tx_valid_i = 1'b0;
    wt(4);
    rts_n_i = 1'b1;
    tick(7);
    chk({7'h00, tx_enabled_o}, 8'h00);
    offer(8'h22);
    offer(8'h33);
    tx_valid_i = 1'b0;
    tick(20);
    chk(8'(got_q.size()), 8'h04);
    rts_n_i = 1'b0;
    wt(6);
    chk(got_q[4], 8'h22);
    chk(got_q[5], 8'h33);
    $display("t_pause done");
  endtask : t_pause
  initial
  begin
    tick(20);
    rstn_i = 1'b1;
    t_cts();
    t_run();
    t_pause();
    summarize();
  end
endmodule : testbench
bind urfc_flow urfc_flow_chk u_urfc_flow_chk(.ref_clk_i, .rstn_i, .rts_n_i, .cts_n_o,
  .rx_space_i, .tx_start_o, .tx_busy_i, .tx_enabled_o);
